// File: gpr_regs.svh
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

`define GPR_ADDR_W 8
`define GPR_DATA_SPACE_OFS 8'h20
`define GPR_D_PIN 8'h09
`define GPR_D_DIR 8'h0A
`define GPR_D_OUT 8'h0B
`define GPR_E_PIN 8'h0C
`define GPR_E_DIR 8'h0D
`define GPR_E_OUT 8'h0E
`define GPR_F_PIN 8'h0F
`define GPR_F_DIR 8'h10
`define GPR_F_OUT 8'h11
`define GPR_G_PIN 8'h12
`define GPR_G_DIR 8'h13
`define GPR_G_OUT 8'h14
`define GPR_H_PIN 8'hD8
`define GPR_H_DIR 8'hD9
`define GPR_H_OUT 8'hDA
`define GPR_J_PIN 8'hDB
`define GPR_J_DIR 8'hDC
`define GPR_J_OUT 8'hDD
`define GPR_CTRL 8'hE0
`define GPR_CTRL_PUD_BIT 0
`define GPR_RESET_VAL 8'h00
`define GPR_G_MASK 8'h1F
`define GPR_J_MASK 8'h7F
`define GPR_FULL_MASK 8'hFF

`endif

// File: gpr_pkg.sv
package gpr_pkg;
   typedef enum logic [2:0] {
      GPR_PORT_D = 3'h0,
      GPR_PORT_E = 3'h1,
      GPR_PORT_F = 3'h2,
      GPR_PORT_G = 3'h3,
      GPR_PORT_H = 3'h4,
      GPR_PORT_J = 3'h5
   } gpr_port_t;
   typedef enum logic [1:0] {
      GPR_KIND_PIN = 2'h0,
      GPR_KIND_DIR = 2'h1,
      GPR_KIND_OUT = 2'h2,
      GPR_KIND_CTRL = 2'h3
   } gpr_kind_t;
   typedef enum logic [0:0] {
      GPR_BUS_IDLE = 1'h0,
      GPR_BUS_ACK = 1'h1
   } gpr_bus_state_t;
endpackage

// File: gpr_port_regs.sv
// Chosen here: the Wishbone register port.
`include "gpr_regs.svh"

// What this block does
// - Output registers eight bits, reset zero.
// - Direction registers read/write, reset to input.
// - Input registers follow pins, reset zero.
// - Port G output bits 7:5 read zero.
// - Port G direction bits 7:5 read zero.
// - Port G input bits 7:5 read zero.
// - Port J bit 7 reads zero everywhere.
// - Ports H and J only on larger variant.
// - Port H only at extended data addresses.
// - Ports D-G decoded at I/O and +0x20.
// - Pull-up when input, output-one, not disabled.
module gpr_port_regs #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int NUM_PORTS = 6
) (
   // System.
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`GPR_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Pins, ports D E F G H J at index 0 to 5.
   input wire logic [NUM_PORTS*8-1:0] pin_i,
   output logic [NUM_PORTS*8-1:0] pin_o,
   output logic [NUM_PORTS*8-1:0] pin_oe_o,
   output logic [NUM_PORTS*8-1:0] pin_pullup_o
);

   // Refuse a port count that the fixed address map cannot serve.
   if (NUM_PORTS != 6) begin : g_bad_ports
      $error("gpr_port_regs serves exactly six ports");
   end

   logic [7:0] out_q [NUM_PORTS];
   logic [7:0] dir_q [NUM_PORTS];
   logic [NUM_PORTS*8-1:0] sync1_q;
   logic [NUM_PORTS*8-1:0] sync2_q;
   logic pud_q;
   gpr_pkg::gpr_bus_state_t bus_q;
   logic hit;
   logic [2:0] sel_port;
   gpr_pkg::gpr_kind_t sel_kind;
   logic [7:0] rd_val;
   logic req;
   logic wr_stb;

   assign req = wb_cyc_i && wb_stb_i && (bus_q == gpr_pkg::GPR_BUS_IDLE);
   assign wr_stb = req && hit && wb_we_i && wb_sel_i[0];

   // Address decode.
   always_comb begin
      hit = 1'b1;
      sel_port = 3'h0;
      sel_kind = gpr_pkg::GPR_KIND_CTRL;
      case (wb_adr_i)
         `GPR_D_PIN, `GPR_D_PIN + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h0;
            sel_kind = gpr_pkg::GPR_KIND_PIN;
         end
         `GPR_D_DIR, `GPR_D_DIR + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h0;
            sel_kind = gpr_pkg::GPR_KIND_DIR;
         end
         `GPR_D_OUT, `GPR_D_OUT + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h0;
            sel_kind = gpr_pkg::GPR_KIND_OUT;
         end
         `GPR_E_PIN, `GPR_E_PIN + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h1;
            sel_kind = gpr_pkg::GPR_KIND_PIN;
         end
         `GPR_E_DIR, `GPR_E_DIR + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h1;
            sel_kind = gpr_pkg::GPR_KIND_DIR;
         end
         `GPR_E_OUT, `GPR_E_OUT + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h1;
            sel_kind = gpr_pkg::GPR_KIND_OUT;
         end
         `GPR_F_PIN, `GPR_F_PIN + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h2;
            sel_kind = gpr_pkg::GPR_KIND_PIN;
         end
         `GPR_F_DIR, `GPR_F_DIR + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h2;
            sel_kind = gpr_pkg::GPR_KIND_DIR;
         end
         `GPR_F_OUT, `GPR_F_OUT + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h2;
            sel_kind = gpr_pkg::GPR_KIND_OUT;
         end
         `GPR_G_PIN, `GPR_G_PIN + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h3;
            sel_kind = gpr_pkg::GPR_KIND_PIN;
         end
         `GPR_G_DIR, `GPR_G_DIR + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h3;
            sel_kind = gpr_pkg::GPR_KIND_DIR;
         end
         `GPR_G_OUT, `GPR_G_OUT + `GPR_DATA_SPACE_OFS: begin
            sel_port = 3'h3;
            sel_kind = gpr_pkg::GPR_KIND_OUT;
         end
         `GPR_H_PIN: begin
            hit = LARGE_VARIANT;
            sel_port = 3'h4;
            sel_kind = gpr_pkg::GPR_KIND_PIN;
         end
         `GPR_H_DIR: begin
            hit = LARGE_VARIANT;
            sel_port = 3'h4;
            sel_kind = gpr_pkg::GPR_KIND_DIR;
         end
         `GPR_H_OUT: begin
            hit = LARGE_VARIANT;
            sel_port = 3'h4;
            sel_kind = gpr_pkg::GPR_KIND_OUT;
         end
         `GPR_J_PIN: begin
            hit = LARGE_VARIANT;
            sel_port = 3'h5;
            sel_kind = gpr_pkg::GPR_KIND_PIN;
         end
         `GPR_J_DIR: begin
            hit = LARGE_VARIANT;
            sel_port = 3'h5;
            sel_kind = gpr_pkg::GPR_KIND_DIR;
         end
         `GPR_J_OUT: begin
            hit = LARGE_VARIANT;
            sel_port = 3'h5;
            sel_kind = gpr_pkg::GPR_KIND_OUT;
         end
         `GPR_CTRL: begin
            sel_kind = gpr_pkg::GPR_KIND_CTRL;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Read mux; pin levels come from the second synchroniser stage.
   always_comb begin
      rd_val = 8'h00;
      case (sel_kind)
         gpr_pkg::GPR_KIND_PIN: rd_val = sync2_q[sel_port*8 +: 8];
         gpr_pkg::GPR_KIND_DIR: rd_val = dir_q[sel_port];
         gpr_pkg::GPR_KIND_OUT: rd_val = out_q[sel_port];
         gpr_pkg::GPR_KIND_CTRL: rd_val = {7'h00, pud_q};
         default: rd_val = 8'h00;
      endcase
   end

   // Bus handshake: ack or err one cycle after request, dropped the cycle after.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= gpr_pkg::GPR_BUS_IDLE;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && hit;
         wb_err_o <= req && !hit;
         bus_q <= req ? gpr_pkg::GPR_BUS_ACK : gpr_pkg::GPR_BUS_IDLE;
         if (req && hit && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, rd_val};
         end
      end
   end

   // Pull-up disable control bit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pud_q <= 1'b0;
      end else if (wr_stb && sel_kind == gpr_pkg::GPR_KIND_CTRL) begin
         pud_q <= wb_dat_i[`GPR_CTRL_PUD_BIT];
      end
   end

   // Per-port storage, synchroniser and pin drive.
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         localparam logic [7:0] MASK = (p == 3) ? `GPR_G_MASK : (p == 5) ? `GPR_J_MASK : `GPR_FULL_MASK;
         localparam logic [7:0] PIN_MASK = (p == 3) ? 8'h1F : MASK;
         localparam bit PRESENT = (p < 4) || LARGE_VARIANT;

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               out_q[p] <= `GPR_RESET_VAL;
               dir_q[p] <= `GPR_RESET_VAL;
            end else if (PRESENT && wr_stb && sel_port == 3'(p)) begin
               if (sel_kind == gpr_pkg::GPR_KIND_OUT) begin
                  out_q[p] <= wb_dat_i[7:0] & MASK;
               end
               if (sel_kind == gpr_pkg::GPR_KIND_DIR) begin
                  dir_q[p] <= wb_dat_i[7:0] & MASK;
               end
            end
         end

         // Two-flop synchroniser; port G bits 7:5 and port J bit 7 are held at zero.
         always_ff @(posedge clk_i) begin
            sync1_q[p*8 +: 8] <= pin_i[p*8 +: 8] & PIN_MASK;
            if (rst_i) begin
               sync2_q[p*8 +: 8] <= 8'h00;
            end else begin
               sync2_q[p*8 +: 8] <= sync1_q[p*8 +: 8];
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               pin_o[p*8 +: 8] <= 8'h00;
               pin_oe_o[p*8 +: 8] <= 8'h00;
               pin_pullup_o[p*8 +: 8] <= 8'h00;
            end else begin
               pin_o[p*8 +: 8] <= out_q[p] & dir_q[p];
               pin_oe_o[p*8 +: 8] <= dir_q[p];
               pin_pullup_o[p*8 +: 8] <= pud_q ? 8'h00 : (out_q[p] & ~dir_q[p]);
            end
         end

         property p_upper_zero;
            @(posedge clk_i) disable iff (rst_i) ((out_q[p] | dir_q[p]) & ~MASK) == 8'h00;
         endproperty
         a_upper_zero: assert property (p_upper_zero) else $error("Unimplemented port bit became set.");
      end
   endgenerate

   property p_out_reset;
      @(posedge clk_i) rst_i |=> (out_q[1] == 8'h00 && out_q[4] == 8'h00);
   endproperty
   a_out_reset: assert property (p_out_reset) else $error("Output register not cleared by reset.");

   property p_dir_reset;
      @(posedge clk_i) rst_i |=> (pin_oe_o == '0 && dir_q[0] == 8'h00);
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("Pins not inputs after reset.");

   property p_sync_delay;
      @(posedge clk_i) disable iff (rst_i)
         ##2 (sync2_q[15:8] == $past(pin_i[15:8], 2));
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("Input register not two cycles behind pin.");

   property p_g_out_mask;
      @(posedge clk_i) disable iff (rst_i) out_q[3][7:5] == 3'h0;
   endproperty
   a_g_out_mask: assert property (p_g_out_mask) else $error("Port G output upper bits set.");

   property p_g_dir_mask;
      @(posedge clk_i) disable iff (rst_i) pin_oe_o[31:29] == 3'h0;
   endproperty
   a_g_dir_mask: assert property (p_g_dir_mask) else $error("Port G direction upper bits set.");

   property p_g_pin_mask;
      @(posedge clk_i) disable iff (rst_i) sync2_q[31:29] == 3'h0;
   endproperty
   a_g_pin_mask: assert property (p_g_pin_mask) else $error("Port G input upper bits set.");

   property p_j_mask;
      @(posedge clk_i) disable iff (rst_i) !out_q[5][7] && !dir_q[5][7] && !sync2_q[47];
   endproperty
   a_j_mask: assert property (p_j_mask) else $error("Port J bit 7 set.");

   property p_small_err;
      @(posedge clk_i) disable iff (rst_i)
         (!LARGE_VARIANT && req && wb_adr_i == `GPR_H_OUT) |=> wb_err_o && !wb_ack_o;
   endproperty
   a_small_err: assert property (p_small_err) else $error("Port H answered on small variant.");

   property p_h_no_short;
      @(posedge clk_i) disable iff (rst_i)
         (req && wb_adr_i == (`GPR_H_OUT - `GPR_DATA_SPACE_OFS)) |=> wb_err_o;
   endproperty
   a_h_no_short: assert property (p_h_no_short) else $error("Port H answered at short address.");

   property p_alias;
      @(posedge clk_i) disable iff (rst_i)
         (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `GPR_E_OUT + `GPR_DATA_SPACE_OFS)
         |=> ##1 (out_q[1] == $past(wb_dat_i[7:0], 2));
   endproperty
   a_alias: assert property (p_alias) else $error("Data-space alias did not write port E.");

   property p_pullup;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |=> pin_pullup_o[7:0] == ($past(pud_q) ? 8'h00 : ($past(out_q[0]) & ~$past(dir_q[0])));
   endproperty
   a_pullup: assert property (p_pullup) else $error("Pull-up does not follow direction and value.");

   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("Ack held longer than one cycle.");

   property p_err_one;
      @(posedge clk_i) disable iff (rst_i) wb_err_o |=> !wb_err_o;
   endproperty
   a_err_one: assert property (p_err_one) else $error("Error held longer than one cycle.");

   property p_ack_err_excl;
      @(posedge clk_i) disable iff (rst_i) !(wb_ack_o && wb_err_o);
   endproperty
   a_ack_err_excl: assert property (p_ack_err_excl) else $error("Ack and error raised together.");

   property p_ack_resp;
      @(posedge clk_i) disable iff (rst_i) (req && hit) |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("Mapped request not acknowledged.");

   property p_err_resp;
      @(posedge clk_i) disable iff (rst_i) (req && !hit) |=> wb_err_o;
   endproperty
   a_err_resp: assert property (p_err_resp) else $error("Unmapped request not refused.");

   property p_rd_upper;
      @(posedge clk_i) disable iff (rst_i) wb_dat_o[31:8] == 24'h00_0000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("Read data upper bytes not zero.");

   property p_pin_drive;
      @(posedge clk_i) disable iff (rst_i) 1'b1 |=> pin_o[15:8] == ($past(out_q[1]) & $past(dir_q[1]));
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("Driven level does not follow registers.");

   property p_oe_follow;
      @(posedge clk_i) disable iff (rst_i) 1'b1 |=> pin_oe_o[15:8] == $past(dir_q[1]);
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("Output enable does not follow direction.");

   property p_pud_reset;
      @(posedge clk_i) rst_i |=> !pud_q;
   endproperty
   a_pud_reset: assert property (p_pud_reset) else $error("Pull-up disable not cleared by reset.");

   property p_pud_off;
      @(posedge clk_i) disable iff (rst_i) pud_q |=> pin_pullup_o == '0;
   endproperty
   a_pud_off: assert property (p_pud_off) else $error("Pull-up active while disabled.");

   property p_err_no_write;
      @(posedge clk_i) disable iff (rst_i) (req && !hit) |=> $stable(out_q[1]) && $stable(dir_q[1]);
   endproperty
   a_err_no_write: assert property (p_err_no_write) else $error("Refused access changed a register.");

   property p_sel_ignored;
      @(posedge clk_i) disable iff (rst_i)
         (req && wb_we_i && !wb_sel_i[0] && wb_adr_i == `GPR_E_OUT) |=> $stable(out_q[1]);
   endproperty
   a_sel_ignored: assert property (p_sel_ignored) else $error("Write without byte enable took effect.");

   property p_pin_readonly;
      @(posedge clk_i) disable iff (rst_i)
         (req && wb_we_i && wb_adr_i == `GPR_E_PIN) |=> $stable(out_q[1]) && $stable(dir_q[1]);
   endproperty
   a_pin_readonly: assert property (p_pin_readonly) else $error("Write to pin levels changed a register.");

   c_write: cover property (@(posedge clk_i) wr_stb);
   c_read: cover property (@(posedge clk_i) req && hit && !wb_we_i);
   c_err: cover property (@(posedge clk_i) wb_err_o);
   c_pud: cover property (@(posedge clk_i) pud_q && |(out_q[0] & ~dir_q[0]));

endmodule

// File: gpr_pin_model.sv
module gpr_pin_model (
   // System.
   input wire logic clk_i,
   input wire logic rst_i,
   // Design side.
   input wire logic [47:0] pin_o,
   input wire logic [47:0] pin_oe_o,
   input wire logic [47:0] pin_pullup_o,
   // Board side.
   input wire logic [47:0] ext_en_i,
   input wire logic [47:0] ext_val_i,
   output logic [47:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [47:0] float_q;
   // A floating pin toggles every cycle so that it never passes for a held level.
   always_ff @(posedge clk_i) begin
      float_q <= rst_i ? 48'h0 : ~float_q;
   end
   assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
      | (~pin_oe_o & ~ext_en_i & (pin_pullup_o | float_q));
endmodule

// File: gpio_port_register_set_tb.sv
module gpio_port_register_set_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc, we, wb_ack_o, wb_err_o, berr;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, wb_dat_o;
   logic [47:0] pin_i, pin_o, pin_oe_o, pin_pullup_o, ext_en, ext_val;
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   localparam logic [7:0] RADR [10] = '{8'h0E, 8'h0D, 8'h14, 8'h13, 8'hDD, 8'hDC, 8'hDA, 8'hD9, 8'h2A, 8'h2E};
   localparam logic [7:0] RMSK [10] = '{8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   gpr_port_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o));
   gpr_pin_model board_u (.clk_i(clk_i), .rst_i(rst_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
      .pin_pullup_o(pin_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i(pin_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Classic single cycle, entered just after a rising edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
      rdat = wb_dat_o;
      berr = wb_err_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(rdat, {24'h0, exp});
   endtask

   task automatic test_reset();
      check({16'h0, pin_oe_o[15:0]}, 32'h0);
      check({16'h0, pin_pullup_o[15:0]}, 32'h0);
      foreach (RADR[i]) rd(RADR[i], 8'h00);
      $display("reset values done");
   endtask

   task automatic test_masks();
      foreach (RADR[i]) begin
         bus(1'b1, RADR[i], 8'hFF);
         rd(RADR[i], RMSK[i]);
         bus(1'b1, RADR[i], 8'h00);
      end
      $display("writable bits done");
   endtask

   task automatic test_refused();
      bus(1'b1, 8'hBA, 8'hFF);
      check({31'h0, berr}, 32'h1);
      bus(1'b0, 8'hD8, 8'h00);
      check({31'h0, berr}, 32'h0);
      sel <= 4'hE;
      bus(1'b1, 8'h0E, 8'hFF);
      sel <= 4'hF;
      rd(8'h0E, 8'h00);
      $display("refused accesses done");
   endtask

   task automatic test_pins();
      ext_en <= {8'hFF, 8'h00, 8'hFF, 8'h00, 8'hF0, 8'h00};
      ext_val <= {8'hFF, 8'h00, 8'hFF, 8'h00, 8'h30, 8'h00};
      bus(1'b1, 8'h0D, 8'h0F);
      bus(1'b1, 8'h0E, 8'hA5);
      repeat (4) @(posedge clk_i);
      check({24'h0, pin_pullup_o[15:8]}, 32'hA0);
      check({24'h0, pin_oe_o[15:8] & pin_o[15:8]}, 32'h05);
      rd(8'h0C, 8'h35);
      rd(8'h2C, 8'h35);
      rd(8'h12, 8'h1F);
      rd(8'hDB, 8'h7F);
      ext_val[15:8] <= 8'hC0;
      repeat (4) @(posedge clk_i);
      rd(8'h0C, 8'hC5);
      bus(1'b1, 8'hE0, 8'h01);
      repeat (2) @(posedge clk_i);
      check({24'h0, pin_pullup_o[15:8]}, 32'h00);
      $display("pin behaviour done");
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      wdat = 32'h0;
      ext_en = 48'h0;
      ext_val = 48'h0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      test_reset();
      test_masks();
      test_refused();
      test_pins();
      results();
   end
endmodule
